// File: pwr_state_pkg.sv
package pwr_state_pkg;

  // ==========================================================================
  // Stop-clock message encodings
  // ==========================================================================
  localparam logic [1:0] SMAF_C2 = 2'h2;
  localparam logic [1:0] SMAF_C3 = 2'h3;

  // ==========================================================================
  // Core voltage select
  // ==========================================================================
  localparam int VSEL_W = 5;
  localparam logic [4:0] VSEL_RESET = 5'h10;
  localparam logic [4:0] VSEL_DSX_DEFAULT = 5'h00;

  // ==========================================================================
  // Timing and sizes
  // ==========================================================================
  localparam int CLK_MHZ = 200;
  localparam int INIT_TIME_NS = 1000;
  localparam int INIT_CYCLES = (INIT_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam int IRQ_W = 8;
  localparam int REF_IDLE_CYCLES = 16;

  // ==========================================================================
  // Power states
  // ==========================================================================
  typedef enum logic [2:0] {
    ST_NORMAL = 3'h0,
    ST_HALT   = 3'h1,
    ST_QUICK  = 3'h2,
    ST_DEEP   = 3'h3,
    ST_DSX    = 3'h4,
    ST_INIT   = 3'h5
  } pstate_t;

  // Stop-clock message from the link
  typedef struct packed {
    logic       valid;
    logic [1:0] smaf;
  } stpclk_msg_t;

  // Block enables towards the rest of the chip
  typedef struct packed {
    logic core_run;
    logic sdram_powersave;
    logic sdram_selfrefresh;
    logic link_gfx_run;
    logic pll_on;
    logic snoop_enable;
  } pwr_ctl_t;

endpackage

// File: pwr_state_ctrl.sv
`timescale 1ns/100ps
module pwr_state_ctrl
  import pwr_state_pkg::*;
#(
  parameter int IRQ_N = pwr_state_pkg::IRQ_W,
  parameter int INIT_N = pwr_state_pkg::INIT_CYCLES
)
(
  // Clock and reset
  input wire logic SYS_CLK_I,
  input wire logic RESET_N_I,
  // Core events
  input wire logic HALT_INSTRUCTION_I,
  input wire logic [IRQ_N-1:0] IRQ_I,
  input wire logic IRQ_ACK_I,
  input wire logic CHIP_RESET_PIN_I,
  input wire logic REFERENCE_CLOCK_IN_I,
  // Link stop-clock messages
  input wire pwr_state_pkg::stpclk_msg_t STPCLK_I,
  input wire logic STPCLK_DEASSERT_I,
  input wire logic SNOOP_REQ_I,
  // Firmware voltage control
  input wire logic [pwr_state_pkg::VSEL_W-1:0] VSEL_FW_I,
  input wire logic [pwr_state_pkg::VSEL_W-1:0] VSEL_DSX_I,
  input wire logic DSX_REQ_I,
  // Status and controls
  output pwr_state_pkg::pstate_t STATE_O,
  output pwr_state_pkg::pwr_ctl_t CTL_O,
  output logic [IRQ_N-1:0] IRQ_PEND_O,
  output logic SNOOP_ACK_O,
  output logic INIT_BUSY_O,
  output logic [pwr_state_pkg::VSEL_W-1:0] CORE_VOLTAGE_SELECT_O
);
  import pwr_state_pkg::*;

  // ==========================================================================
  // Pin synchronisers
  // ==========================================================================
  // Three stages; a change counts once stages two and three agree
  logic [2:0] rst_sync_r;
  logic [2:0] ref_sync_r;
  logic rst_pin_r;
  logic ref_lvl_r;
  logic [4:0] ref_idle_r;
  logic [4:0] ref_idle_nxt;

  always_ff @(posedge SYS_CLK_I or negedge RESET_N_I)
  begin
    if (!RESET_N_I)
    begin
      rst_sync_r <= 3'h0;
      ref_sync_r <= 3'h0;
      rst_pin_r <= 1'b0;
      ref_lvl_r <= 1'b0;
      ref_idle_r <= 5'h00;
    end
    else
    begin
      rst_sync_r <= {rst_sync_r[1:0], CHIP_RESET_PIN_I};
      ref_sync_r <= {ref_sync_r[1:0], REFERENCE_CLOCK_IN_I};
      if (rst_sync_r[1] == rst_sync_r[2])
        rst_pin_r <= rst_sync_r[2];
      if (ref_sync_r[1] == ref_sync_r[2])
        ref_lvl_r <= ref_sync_r[2];
      ref_idle_r <= ref_idle_nxt;
    end
  end

  // Reference clock counts as stopped after a run of cycles with no edge
  wire ref_edge = (ref_sync_r[1] == ref_sync_r[2]) && (ref_sync_r[2] != ref_lvl_r);
  wire ref_stopped = (ref_idle_r == 5'(REF_IDLE_CYCLES));
  always_comb
  begin
    ref_idle_nxt = ref_idle_r;
    if (ref_edge)
      ref_idle_nxt = 5'h00;
    else if (!ref_stopped)
      ref_idle_nxt = ref_idle_r + 5'h01;
  end

  wire reset_seen = rst_pin_r && !ref_stopped;

  // ==========================================================================
  // State machine
  // ==========================================================================
  pstate_t state_r;
  pstate_t state_nxt;
  logic [IRQ_N-1:0] pend_r;
  logic [IRQ_N-1:0] pend_nxt;
  logic [15:0] init_cnt_r;
  logic [15:0] init_cnt_nxt;

  wire any_irq = |IRQ_I;
  wire msg_c2 = STPCLK_I.valid && (STPCLK_I.smaf == SMAF_C2);
  wire msg_c3 = STPCLK_I.valid && (STPCLK_I.smaf == SMAF_C3);
  wire from_run = (state_r == ST_NORMAL) || (state_r == ST_HALT);

  // Next state; in Normal, Halt and Quick reset wins over all other events; Deep, DSX and Init ignore it
  always_comb
  begin
    state_nxt = state_r;
    init_cnt_nxt = init_cnt_r;
    unique case (state_r)
      ST_NORMAL, ST_HALT:
      begin
        if (reset_seen)
          state_nxt = ST_INIT;
        else if (msg_c3)
          state_nxt = ST_DEEP;
        else if (msg_c2)
          state_nxt = ST_QUICK;
        else if (state_r == ST_HALT && any_irq)
          state_nxt = ST_NORMAL;
        else if (state_r == ST_NORMAL && HALT_INSTRUCTION_I)
          state_nxt = ST_HALT;
        if (state_nxt == ST_INIT)
          init_cnt_nxt = 16'(INIT_N);
      end
      ST_QUICK:
      begin
        if (reset_seen)
        begin
          state_nxt = ST_INIT;
          init_cnt_nxt = 16'(INIT_N);
        end
        else if (STPCLK_DEASSERT_I)
          state_nxt = ST_NORMAL;
      end
      ST_DEEP:
      begin
        if (DSX_REQ_I)
          state_nxt = ST_DSX;
        else if (STPCLK_DEASSERT_I)
          state_nxt = ST_NORMAL;
      end
      ST_DSX:
      begin
        if (!DSX_REQ_I)
          state_nxt = ST_DEEP;
      end
      ST_INIT:
      begin
        if (init_cnt_r == 16'h0000)
          state_nxt = ST_NORMAL;
        else
          init_cnt_nxt = init_cnt_r - 16'h0001;
      end
      default:
        state_nxt = ST_NORMAL;
    endcase
  end

  // Interrupt latches: set only in Quick, cleared by acknowledge only in Normal
  always_comb
  begin
    pend_nxt = pend_r;
    if (IRQ_ACK_I && state_r == ST_NORMAL)
      pend_nxt = '0;
    if (state_r == ST_QUICK)
      pend_nxt = pend_r | IRQ_I;
    if (state_r == ST_DEEP || state_r == ST_DSX || state_r == ST_INIT)
      pend_nxt = '0;
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  pwr_ctl_t ctl_nxt;
  logic [VSEL_W-1:0] vsel_nxt;
  wire sleeping = (state_nxt == ST_DEEP) || (state_nxt == ST_DSX);

  // Controls follow the next state so they change with it
  always_comb
  begin
    ctl_nxt.core_run = (state_nxt == ST_NORMAL);
    ctl_nxt.sdram_powersave = (state_nxt == ST_QUICK);
    ctl_nxt.sdram_selfrefresh = sleeping;
    ctl_nxt.link_gfx_run = !sleeping;
    ctl_nxt.pll_on = !sleeping;
    ctl_nxt.snoop_enable = !sleeping;
    vsel_nxt = (state_nxt == ST_DSX) ? VSEL_DSX_I : VSEL_FW_I;
  end

  always_ff @(posedge SYS_CLK_I or negedge RESET_N_I)
  begin
    if (!RESET_N_I)
    begin
      state_r <= ST_NORMAL;
      pend_r <= '0;
      init_cnt_r <= 16'h0000;
      CTL_O <= '{1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1};
      CORE_VOLTAGE_SELECT_O <= VSEL_RESET;
      STATE_O <= ST_NORMAL;
      IRQ_PEND_O <= '0;
      SNOOP_ACK_O <= 1'b0;
      INIT_BUSY_O <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      pend_r <= pend_nxt;
      init_cnt_r <= init_cnt_nxt;
      CTL_O <= ctl_nxt;
      CORE_VOLTAGE_SELECT_O <= vsel_nxt;
      STATE_O <= state_nxt;
      IRQ_PEND_O <= (state_nxt == ST_NORMAL) ? (pend_nxt | IRQ_I) : '0;
      SNOOP_ACK_O <= SNOOP_REQ_I && !(state_r == ST_DEEP || state_r == ST_DSX);
      INIT_BUSY_O <= (state_nxt == ST_INIT);
    end
  end

endmodule

// File: pwr_state_ctrl_assertions.sv
`timescale 1ns/100ps
module pwr_state_ctrl_assertions
  import pwr_state_pkg::*;
#(
  parameter int IRQ_N = 8
)
(
  // Clock and reset
  input wire logic SYS_CLK_I,
  input wire logic RESET_N_I,
  // Watched inputs
  input wire logic HALT_INSTRUCTION_I,
  input wire logic [IRQ_N-1:0] IRQ_I,
  input wire pwr_state_pkg::stpclk_msg_t STPCLK_I,
  input wire logic SNOOP_REQ_I,
  // Watched outputs
  input wire pwr_state_pkg::pstate_t STATE_O,
  input wire pwr_state_pkg::pwr_ctl_t CTL_O,
  input wire logic [IRQ_N-1:0] IRQ_PEND_O,
  input wire logic SNOOP_ACK_O
);
  // ====
  // State checks; messages are one-shot, so entry is due on the next edge
  default clocking @(posedge SYS_CLK_I); endclocking
  default disable iff (!RESET_N_I);
  wire awake = STATE_O inside {ST_NORMAL, ST_HALT};
  AST_HALT_IN:
    assert property (STATE_O == ST_NORMAL && HALT_INSTRUCTION_I && !STPCLK_I.valid
      && IRQ_I == '0 |=> STATE_O inside {ST_HALT, ST_INIT}) else $error("halt entry");
  AST_HALT_CTL:
    assert property (STATE_O == ST_HALT |-> !CTL_O.core_run && CTL_O.link_gfx_run
      && CTL_O.snoop_enable) else $error("halt controls");
  AST_C2:
    assert property (awake && STPCLK_I.valid && STPCLK_I.smaf == SMAF_C2
      |=> STATE_O inside {ST_QUICK, ST_INIT}) else $error("quick entry");
  AST_C3:
    assert property (awake && STPCLK_I.valid && STPCLK_I.smaf == SMAF_C3
      |=> STATE_O inside {ST_DEEP, ST_INIT}) else $error("deep entry");
  AST_QUICK:
    assert property (STATE_O == ST_QUICK |-> CTL_O.sdram_powersave && CTL_O.link_gfx_run
      && !CTL_O.core_run && IRQ_PEND_O == '0) else $error("quick controls");
  AST_DEEP:
    assert property (STATE_O inside {ST_DEEP, ST_DSX} |-> !CTL_O.pll_on
      && CTL_O.sdram_selfrefresh && !CTL_O.link_gfx_run) else $error("deep controls");
  AST_SNOOP:
    assert property (SNOOP_REQ_I && STATE_O inside {ST_NORMAL, ST_HALT, ST_QUICK}
      |=> SNOOP_ACK_O || STATE_O inside {ST_DEEP, ST_DSX, ST_INIT}) else $error("snoop lost");
  AST_NO_SNOOP:
    assert property ((STATE_O inside {ST_DEEP, ST_DSX})[*2] |-> !SNOOP_ACK_O)
      else $error("deep snoop");
endmodule

bind pwr_state_ctrl pwr_state_ctrl_assertions #(.IRQ_N(IRQ_N)) u_chk (.SYS_CLK_I(SYS_CLK_I),
  .RESET_N_I(RESET_N_I), .HALT_INSTRUCTION_I(HALT_INSTRUCTION_I), .IRQ_I(IRQ_I),
  .STPCLK_I(STPCLK_I), .SNOOP_REQ_I(SNOOP_REQ_I), .STATE_O(STATE_O), .CTL_O(CTL_O),
  .IRQ_PEND_O(IRQ_PEND_O), .SNOOP_ACK_O(SNOOP_ACK_O));

// File: sb_model.sv
`timescale 1ns/100ps
module sb_model
  import pwr_state_pkg::*;
(
  // Clock
  input wire logic clk_i,
  // Stop-clock traffic
  output pwr_state_pkg::stpclk_msg_t msg_o,
  output logic deassert_o
);
  // ====
  // Idle link
  initial
  begin
    msg_o = '0;
    deassert_o = 1'b0;
  end
  task send(input logic [1:0] code);
    msg_o = '{1'b1, code};
    @(posedge clk_i);
    #1 msg_o = '{1'b0, ~code};
  endtask
  task wake(input int wait_n);
    repeat (wait_n) @(posedge clk_i);
    #1 deassert_o = 1'b1;
    @(posedge clk_i);
    #1 deassert_o = 1'b0;
  endtask
endmodule

// File: processor_power_state_control_tb.sv
`timescale 1ns/100ps
module processor_power_state_control_tb;
  import pwr_state_pkg::*;
  // ====
  // Signals
  logic clk, rst_n, halt, ack, crst, ref_run, ref_clk, ref_div, snp, extended_deep_sleep, deas, sack, busy;
  logic [7:0] irq, pend, bit_m;
  logic [4:0] vdsx, vsel;
  stpclk_msg_t msg;
  pstate_t st;
  pwr_ctl_t ctl;
  int err_total, n_compared;

  pwr_state_ctrl #(.INIT_N(4)) uut (.SYS_CLK_I(clk), .RESET_N_I(rst_n), .HALT_INSTRUCTION_I(halt),
    .IRQ_I(irq), .IRQ_ACK_I(ack), .CHIP_RESET_PIN_I(crst), .REFERENCE_CLOCK_IN_I(ref_clk),
    .STPCLK_I(msg), .STPCLK_DEASSERT_I(deas), .SNOOP_REQ_I(snp), .VSEL_FW_I(~vdsx),
    .VSEL_DSX_I(vdsx), .DSX_REQ_I(extended_deep_sleep), .STATE_O(st), .CTL_O(ctl), .IRQ_PEND_O(pend),
    .SNOOP_ACK_O(sack), .INIT_BUSY_O(busy), .CORE_VOLTAGE_SELECT_O(vsel));
  sb_model sb (.clk_i(clk), .msg_o(msg), .deassert_o(deas));

  // Clock
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // Reference clock at a quarter of the system rate, so the pin filter sees each level
  // twice; a faster toggle never settles in the filter; stoppable for the reset test
  always @(posedge clk)
  begin
    ref_div <= ~ref_div;
    if (ref_run && ref_div)
      ref_clk <= ~ref_clk;
  end

  task cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp)
    begin
      err_total++;
      $display("MISMATCH %s exp %h got %h", nm, exp, got);
    end
  endtask
  // Bounded wait for a state, then compare
  task go(input pstate_t s);
    for (int i = 0; i < 40 && st !== s; i++)
      cyc(1);
    chk("state", 8'(s), 8'(st));
  endtask
  task stop_test;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // Watchdog
  initial
  begin
    #20000;
    err_total++;
    stop_test;
  end

  // ====
  // Tests
  initial
  begin
    {rst_n, halt, ack, crst, snp, extended_deep_sleep, ref_clk, ref_div, irq} = '0;
    ref_run = 1'b1;
    err_total = 0;
    n_compared = 0;
    void'($urandom(32'ha6ff));
    vdsx = 5'($urandom);
    bit_m = 8'h01 << ($urandom % 8);
    cyc(3);
    rst_n = 1'b1;
    chk("vsel", VSEL_RESET, vsel);
    chk("ctl", 8'h27, 8'(ctl));
    cyc(4);
    $display("test reset done");
    halt = 1'b1;
    cyc(1);
    halt = 1'b0;
    chk("state", ST_HALT, st);
    irq = bit_m;
    cyc(1);
    irq = '0;
    chk("state", ST_NORMAL, st);
    ack = 1'b1;
    cyc(1);
    halt = 1'b1;
    ack = 1'b0;
    cyc(1);
    halt = 1'b0;
    sb.send(SMAF_C2);
    chk("state", ST_QUICK, st);
    snp = 1'b1;
    cyc(1);
    snp = 1'b0;
    chk("snoop", 8'h01, sack);
    // Same interrupt twice; only one occurrence may be kept
    repeat (2)
    begin
      irq = bit_m;
      cyc(1);
      irq = '0;
      cyc(1);
    end
    chk("pend", 8'h00, pend);
    sb.wake(2);
    chk("pend", bit_m, pend);
    ack = 1'b1;
    cyc(1);
    ack = 1'b0;
    chk("pend", 8'h00, pend);
    $display("test halt and quick start done");
    sb.send(SMAF_C3);
    chk("state", ST_DEEP, st);
    {snp, extended_deep_sleep, irq} = {2'b11, bit_m};
    cyc(1);
    chk("vsel", vdsx, vsel);
    {extended_deep_sleep, irq} = '0;
    cyc(1);
    chk("snoop", 8'h00, sack);
    sb.wake(8);
    snp = 1'b0;
    chk("pend", 8'h00, pend);
    // Back in Normal the firmware setting must drive the regulator again
    chk("vsel", {3'h0, ~vdsx}, vsel);
    $display("test deep sleep done");
    ref_run = 1'b0;
    cyc(20);
    crst = 1'b1;
    cyc(6);
    // A honoured reset would already show Init here
    chk("state", ST_NORMAL, st);
    crst = 1'b0;
    cyc(4);
    chk("state", ST_NORMAL, st);
    ref_run = 1'b1;
    cyc(20);
    sb.send(SMAF_C2);
    crst = 1'b1;
    cyc(2);
    crst = 1'b0;
    go(ST_INIT);
    chk("busy", 8'h01, busy);
    go(ST_NORMAL);
    $display("test chip reset done");
    stop_test;
  end
endmodule
